// ==== hw/ccr_regs.sv ====
// module: channel calibration and configuration register bank, wishbone slave
module ccr_regs
    import ccr_pkg::*;
#(
    parameter int ADDR_W = 8
)(
    input  wire logic                  CLOCK_IN,
    input  wire logic                  RESET_IN,
    input  wire logic                  WB_CYC_IN,
    input  wire logic                  WB_STB_IN,
    input  wire logic                  WB_WE_IN,
    input  wire logic [ADDR_W-1:0]     WB_ADR_IN,
    input  wire logic [CCR_SEL_W-1:0]  WB_SEL_IN,
    input  wire logic [CCR_DATA_W-1:0] WB_DAT_IN,
    output logic      [CCR_DATA_W-1:0] WB_DAT_OUT,
    output logic                       WB_ACK_OUT,
    output logic      [CCR_CAL_W-1:0]  CH0_GAIN_OUT,
    output logic      [CCR_CAL_W-1:0]  CH1_GAIN_OUT,
    output logic      [CCR_CAL_W-1:0]  CH1_OFFSET_OUT,
    output logic      [CCR_DELAY_W-1:0] CH1_DELAY_OUT,
    output ccr_input_sel_t             CH1_INPUT_SEL_OUT,
    output logic      [CCR_COEFF_W-1:0] CH1_DC_COEFF_OUT
);

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic in_bank(input logic [CCR_IDX_W-1:0] idx);
        in_bank = (idx >= CCR_IDX_CH0_GAIN_HIGH) && (idx <= CCR_IDX_CH1_GAIN_LOW);
    endfunction : in_bank

    function automatic logic [2:0] bank_slot(input logic [CCR_IDX_W-1:0] idx);
        logic [CCR_IDX_W-1:0] diff;
        diff      = idx - CCR_IDX_CH0_GAIN_HIGH;
        bank_slot = diff[2:0];
    endfunction : bank_slot

    // byte lanes 0 and 1 carry the 16-bit register; lanes 2 and 3 are unused
    function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
                                               input logic [15:0] new_v,
                                               input logic [1:0]  sel);
        lane_merge[7:0]  = sel[0] ? new_v[7:0]  : old_v[7:0];
        lane_merge[15:8] = sel[1] ? new_v[15:8] : old_v[15:8];
    endfunction : lane_merge

    // ------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------
    logic                  ack_q;
    logic                  req;
    logic                  wr_fire;
    logic [CCR_IDX_W-1:0]  idx;
    logic [15:0]           wdat;

    assign req     = WB_CYC_IN && WB_STB_IN;
    // the write lands on the edge where the master sees ack, never earlier
    assign wr_fire = req && WB_WE_IN && ack_q;
    assign idx     = WB_ADR_IN[CCR_IDX_W+1:2];
    assign wdat    = WB_DAT_IN[CCR_REG_W-1:0];

    // one wait cycle, then a one-cycle ack; unmapped indices also ack
    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req && !ack_q;
        end
    end

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    logic [15:0] bank_q [CCR_BANK_N];
    logic [3:0]  global_dc_q;

    genvar gi;
    generate
        for (gi = 0; gi < CCR_BANK_N; gi++) begin : g_bank
            always_ff @(posedge CLOCK_IN) begin
                if (RESET_IN) begin
                    bank_q[gi] <= CCR_RESET[gi];
                end else if (wr_fire && in_bank(idx) && bank_slot(idx) == 3'(gi)) begin
                    // reserved bits masked to zero on every write
                    bank_q[gi] <= lane_merge(bank_q[gi], wdat, WB_SEL_IN[1:0])
                                  & CCR_WMASK[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            global_dc_q <= CCR_GLOBAL_DC_RESET;
        end else if (wr_fire && idx == CCR_IDX_GLOBAL_DC && WB_SEL_IN[0]) begin
            global_dc_q <= wdat[CCR_COEFF_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // dc filter resolution
    // ------------------------------------------------------------
    logic [3:0] eff_coeff;
    logic       eff_active;
    logic       ch1_off;
    logic       active_q;

    assign ch1_off = bank_q[2][CCR_DC_OFF_BIT];

    ccr_dc_resolve u_dc (
        .global_coeff_in (global_dc_q),
        .chan_off_in     (ch1_off),
        .eff_coeff_out   (eff_coeff),
        .active_out      (eff_active)
    );

    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            CH1_DC_COEFF_OUT <= CCR_COEFF_OFF;
            active_q         <= 1'b0;
        end else begin
            CH1_DC_COEFF_OUT <= eff_coeff;
            active_q         <= eff_active;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    logic [15:0] rd_word;

    always_comb begin
        rd_word = 16'h0000;
        if (in_bank(idx)) begin
            rd_word = bank_q[bank_slot(idx)];
        end else if (idx == CCR_IDX_GLOBAL_DC) begin
            rd_word[CCR_COEFF_W-1:0] = global_dc_q;
        end else if (idx == CCR_IDX_STATUS) begin
            rd_word[CCR_COEFF_W-1:0] = CH1_DC_COEFF_OUT;
            rd_word[CCR_ACTIVE_BIT]  = active_q;
        end
    end

    // data is captured with the ack so it stands exactly while ack is high
    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            WB_DAT_OUT <= 32'h0000_0000;
        end else if (req && !ack_q && !WB_WE_IN) begin
            WB_DAT_OUT <= {16'h0000, rd_word};
        end else begin
            WB_DAT_OUT <= 32'h0000_0000;
        end
    end

    assign WB_ACK_OUT = ack_q;

    // ------------------------------------------------------------
    // calibration and channel outputs
    // ------------------------------------------------------------
    // gain is an unsigned fraction, 800000h is unity; offset is signed
    assign CH0_GAIN_OUT   = {bank_q[0], bank_q[1][15:CCR_LOW_LSB]};
    assign CH1_OFFSET_OUT = {bank_q[3], bank_q[4][15:CCR_LOW_LSB]};
    assign CH1_GAIN_OUT   = {bank_q[5], bank_q[6][15:CCR_LOW_LSB]};
    // signed count of modulator clocks, two's complement
    assign CH1_DELAY_OUT  = bank_q[2][CCR_DELAY_LSB +: CCR_DELAY_W];
    assign CH1_INPUT_SEL_OUT = ccr_input_sel_t'(bank_q[2][CCR_INSEL_LSB +: CCR_INSEL_W]);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (RESET_IN);

    sequence s_read(logic [4:0] ri);
        req && !WB_WE_IN && !ack_q && idx == ri ##1 WB_ACK_OUT;
    endsequence

    sequence s_write(logic [4:0] wi);
        req && WB_WE_IN && ack_q && idx == wi && WB_SEL_IN[1:0] == 2'h3;
    endsequence

    AST_ACK_LATENCY: assert property (req && !ack_q |=> WB_ACK_OUT ##1 !WB_ACK_OUT)
        else $error("ack not one cycle after request");

    AST_RESET_STATE: assert property ($past(RESET_IN) |->
        CH0_GAIN_OUT == CCR_GAIN_UNITY && CH1_GAIN_OUT == CCR_GAIN_UNITY
        && CH1_OFFSET_OUT == 24'h000000 && CH1_DELAY_OUT == 10'h000)
        else $error("bad reset value");

    AST_CH0_LOW_READ: assert property (s_read(CCR_IDX_CH0_GAIN_LOW) |->
        WB_DAT_OUT[7:0] == 8'h00 && WB_DAT_OUT[15:8] == CH0_GAIN_OUT[7:0])
        else $error("channel 0 gain low read wrong");

    AST_OFS_LOW_READ: assert property (s_read(CCR_IDX_CH1_OFS_LOW) |->
        WB_DAT_OUT[7:0] == 8'h00 && WB_DAT_OUT[15:8] == CH1_OFFSET_OUT[7:0])
        else $error("offset low read wrong");

    AST_GAIN_LOW_WRITE: assert property (s_write(CCR_IDX_CH1_GAIN_LOW) |=>
        CH1_GAIN_OUT[7:0] == $past(WB_DAT_IN[15:8]) ##1 !WB_ACK_OUT)
        else $error("gain low write wrong");

    AST_GAIN_HIGH_WRITE: assert property (s_write(CCR_IDX_CH1_GAIN_HIGH) |=>
        CH1_GAIN_OUT[23:8] == $past(WB_DAT_IN[15:0]))
        else $error("gain high write wrong");

    AST_CH0_HIGH_WRITE: assert property (s_write(CCR_IDX_CH0_GAIN_HIGH) |=>
        CH0_GAIN_OUT[23:8] == $past(WB_DAT_IN[15:0]))
        else $error("channel 0 gain high write wrong");

    AST_OFS_HIGH_WRITE: assert property (s_write(CCR_IDX_CH1_OFS_HIGH) |=>
        CH1_OFFSET_OUT[23:8] == $past(WB_DAT_IN[15:0]))
        else $error("offset high write wrong");

    AST_SETUP_WRITE: assert property (s_write(CCR_IDX_CH1_SETUP) |=>
        CH1_DELAY_OUT == $past(WB_DAT_IN[15:6])
        && CH1_INPUT_SEL_OUT == ccr_input_sel_t'($past(WB_DAT_IN[1:0])))
        else $error("setup fields not taken");

    AST_SETUP_RESERVED: assert property (s_read(CCR_IDX_CH1_SETUP) |->
        WB_DAT_OUT[5:3] == 3'h0 && WB_DAT_OUT[31:16] == 16'h0000)
        else $error("setup reserved bits not zero");

    AST_DC_OFF: assert property (ch1_off |=> CH1_DC_COEFF_OUT == CCR_COEFF_OFF)
        else $error("disabled channel filter still on");

    AST_DC_FOLLOW: assert property (!ch1_off |=> CH1_DC_COEFF_OUT == $past(global_dc_q))
        else $error("channel filter does not follow global coefficient");

    // ------------------------------------------------------------
    // bus framing assertions
    // ------------------------------------------------------------
    // an unmapped index must still answer, or the master would hang
    sequence s_read_unmapped;
        req && !WB_WE_IN && !ack_q && !in_bank(idx)
        && idx != CCR_IDX_GLOBAL_DC && idx != CCR_IDX_STATUS ##1 WB_ACK_OUT;
    endsequence

    AST_ACK_PULSE: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
        else $error("ack held longer than one cycle");

    AST_ACK_CAUSE: assert property (WB_ACK_OUT |-> $past(req))
        else $error("ack without a request");

    AST_NO_ACK_IDLE: assert property (!req |=> !WB_ACK_OUT)
        else $error("ack raised while the bus is idle");

    AST_DATA_IDLE_ZERO: assert property (!WB_ACK_OUT |-> WB_DAT_OUT == 32'h0000_0000)
        else $error("read data shown outside ack");

    AST_WRITE_NO_DATA: assert property (req && WB_WE_IN && !ack_q |=> WB_DAT_OUT == 32'h0000_0000)
        else $error("read data shown on a write");

    AST_DATA_UPPER_ZERO: assert property (WB_DAT_OUT[31:16] == 16'h0000)
        else $error("unused read lanes not zero");

    // ------------------------------------------------------------
    // read-back assertions
    // ------------------------------------------------------------
    // the read word is captured a cycle before the outputs are compared; no write can land between
    AST_CH0_HIGH_READ: assert property (s_read(CCR_IDX_CH0_GAIN_HIGH) |->
        WB_DAT_OUT[15:0] == CH0_GAIN_OUT[23:8])
        else $error("channel 0 gain high read wrong");

    AST_OFS_HIGH_READ: assert property (s_read(CCR_IDX_CH1_OFS_HIGH) |->
        WB_DAT_OUT[15:0] == CH1_OFFSET_OUT[23:8])
        else $error("offset high read wrong");

    AST_GAIN_HIGH_READ: assert property (s_read(CCR_IDX_CH1_GAIN_HIGH) |->
        WB_DAT_OUT[15:0] == CH1_GAIN_OUT[23:8])
        else $error("gain high read wrong");

    AST_GAIN_LOW_READ: assert property (s_read(CCR_IDX_CH1_GAIN_LOW) |->
        WB_DAT_OUT[7:0] == 8'h00 && WB_DAT_OUT[15:8] == CH1_GAIN_OUT[7:0])
        else $error("gain low read wrong");

    AST_SETUP_READ: assert property (s_read(CCR_IDX_CH1_SETUP) |->
        WB_DAT_OUT[15:6] == CH1_DELAY_OUT && WB_DAT_OUT[1:0] == CH1_INPUT_SEL_OUT && WB_DAT_OUT[2] == ch1_off)
        else $error("setup read wrong");

    AST_UNMAPPED_READ: assert property (s_read_unmapped |->
        WB_DAT_OUT == 32'h0000_0000)
        else $error("unmapped read not zero");

    AST_STATUS_READ: assert property (s_read(CCR_IDX_STATUS) |->
        WB_DAT_OUT[3:0] == CH1_DC_COEFF_OUT && WB_DAT_OUT[4] == active_q)
        else $error("status read wrong");

    // ------------------------------------------------------------
    // write and reset assertions
    // ------------------------------------------------------------
    AST_CH0_LOW_WRITE: assert property (s_write(CCR_IDX_CH0_GAIN_LOW) |=>
        CH0_GAIN_OUT[7:0] == $past(WB_DAT_IN[15:8]))
        else $error("channel 0 gain low write wrong");

    AST_OFS_LOW_WRITE: assert property (s_write(CCR_IDX_CH1_OFS_LOW) |=>
        CH1_OFFSET_OUT[7:0] == $past(WB_DAT_IN[15:8]))
        else $error("offset low write wrong");

    AST_DC_OFF_WRITE: assert property (s_write(CCR_IDX_CH1_SETUP) |=>
        ch1_off == $past(WB_DAT_IN[2]))
        else $error("filter disable bit not taken");

    // a single-lane write must leave the other byte alone
    AST_LANE_KEEP: assert property (req && WB_WE_IN && ack_q && idx == CCR_IDX_CH0_GAIN_HIGH
        && WB_SEL_IN[1:0] == 2'h1 |=> CH0_GAIN_OUT[23:16] == $past(CH0_GAIN_OUT[23:16]))
        else $error("unselected byte lane changed");

    AST_GLOBAL_WRITE: assert property (req && WB_WE_IN && ack_q && idx == CCR_IDX_GLOBAL_DC
        && WB_SEL_IN[0] |=> global_dc_q == $past(WB_DAT_IN[3:0]))
        else $error("global coefficient write wrong");

    AST_RESET_LOW_REGS: assert property ($past(RESET_IN) |->
        bank_q[1] == 16'h0000 && bank_q[2] == 16'h0000 && bank_q[4] == 16'h0000
        && bank_q[6] == 16'h0000 && CH1_DC_COEFF_OUT == CCR_COEFF_OFF)
        else $error("low registers not reset");

    AST_RESERVED_HELD: assert property (bank_q[1][7:0] == 8'h00 && bank_q[4][7:0] == 8'h00
        && bank_q[6][7:0] == 8'h00 && bank_q[2][5:3] == 3'h0)
        else $error("reserved bits not zero");

    AST_ACTIVE_MATCH: assert property (active_q == (CH1_DC_COEFF_OUT != CCR_COEFF_OFF))
        else $error("filter active flag disagrees with coefficient");

endmodule : ccr_regs

// ==== hw/ccr_pkg.sv ====
// package: register map, field layout and reset values of the calibration bank
package ccr_pkg;

    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int CCR_DATA_W = 32;
    localparam int CCR_REG_W  = 16;
    localparam int CCR_IDX_W  = 5;
    localparam int CCR_SEL_W  = 4;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [4:0] CCR_IDX_CH0_GAIN_HIGH = 5'h0c;
    localparam logic [4:0] CCR_IDX_CH0_GAIN_LOW  = 5'h0d;
    localparam logic [4:0] CCR_IDX_CH1_SETUP     = 5'h0e;
    localparam logic [4:0] CCR_IDX_CH1_OFS_HIGH  = 5'h0f;
    localparam logic [4:0] CCR_IDX_CH1_OFS_LOW   = 5'h10;
    localparam logic [4:0] CCR_IDX_CH1_GAIN_HIGH = 5'h11;
    localparam logic [4:0] CCR_IDX_CH1_GAIN_LOW  = 5'h12;
    localparam logic [4:0] CCR_IDX_GLOBAL_DC     = 5'h1c;
    localparam logic [4:0] CCR_IDX_STATUS        = 5'h1d;
    localparam int         CCR_BANK_N            = 7;

    // ------------------------------------------------------------
    // reset values and writable bits, bank order from index 0x0c
    // ------------------------------------------------------------
    localparam logic [15:0] CCR_RESET [CCR_BANK_N] = '{
        16'h8000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h8000, 16'h0000
    };
    localparam logic [15:0] CCR_WMASK [CCR_BANK_N] = '{
        16'hffff, 16'hff00, 16'hffc7, 16'hffff, 16'hff00, 16'hffff, 16'hff00
    };
    localparam logic [3:0] CCR_GLOBAL_DC_RESET = 4'h0;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CCR_DELAY_LSB  = 6;
    localparam int CCR_DELAY_W    = 10;
    localparam int CCR_DC_OFF_BIT = 2;
    localparam int CCR_INSEL_LSB  = 0;
    localparam int CCR_INSEL_W    = 2;
    localparam int CCR_LOW_LSB    = 8;
    localparam int CCR_COEFF_W    = 4;
    localparam int CCR_CAL_W      = 24;
    localparam int CCR_ACTIVE_BIT = 4;

    localparam logic [23:0] CCR_GAIN_UNITY = 24'h800000;
    localparam logic [3:0]  CCR_COEFF_OFF  = 4'h0;

    typedef enum logic [1:0] {
        CCR_IN_PAIR,
        CCR_IN_SHORTED,
        CCR_IN_POS_TEST,
        CCR_IN_NEG_TEST
    } ccr_input_sel_t;

endpackage : ccr_pkg

// ==== hw/ccr_dc_resolve.sv ====
// module: effective dc filter coefficient of one channel
module ccr_dc_resolve
    import ccr_pkg::*;
(
    input  wire logic [3:0] global_coeff_in,
    input  wire logic       chan_off_in,
    output logic      [3:0] eff_coeff_out,
    output logic            active_out
);

    // ------------------------------------------------------------
    // per-channel disable overrides the shared setting
    // ------------------------------------------------------------
    // 0 means off; 1..15 halve the coefficient from 1/4 to 1/65536
    always_comb begin
        if (chan_off_in) begin
            eff_coeff_out = CCR_COEFF_OFF;
        end else begin
            eff_coeff_out = global_coeff_in;
        end
        active_out = (eff_coeff_out != CCR_COEFF_OFF);
    end

endmodule : ccr_dc_resolve

// ==== bench/ccr_regs_tb.sv ====
// testbench: register bank driven over classic wishbone, results checked against the map
module ccr_regs_tb
    import ccr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic           clock, reset, cyc, stb, we;
    logic [7:0]     adr;
    logic [3:0]     sel;
    logic [31:0]    wdat, rdat;
    logic           ack;
    logic [23:0]    ch0_gain, ch1_gain, ch1_ofs;
    logic [9:0]     ch1_delay;
    ccr_input_sel_t ch1_insel;
    logic [3:0]     ch1_dc;
    int             error_cnt = 0;
    int             n_checks  = 0;
    logic [15:0]    rst_val [7] = '{16'h8000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h8000, 16'h0000};
    logic [15:0]    wr_mask [7] = '{16'hffff, 16'hff00, 16'hffc7, 16'hffff, 16'hff00, 16'hffff, 16'hff00};

    ccr_regs dut (
        .CLOCK_IN(clock), .RESET_IN(reset), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
        .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack),
        .CH0_GAIN_OUT(ch0_gain), .CH1_GAIN_OUT(ch1_gain), .CH1_OFFSET_OUT(ch1_ofs),
        .CH1_DELAY_OUT(ch1_delay), .CH1_INPUT_SEL_OUT(ch1_insel), .CH1_DC_COEFF_OUT(ch1_dc)
    );

    // ------------------------------------------------------------
    // clock, reset, watchdog
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // about 55 bus cycles (some 200 clocks) are needed, so 20000 clocks only trips on a hang
    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        conclude();
    end

    // ------------------------------------------------------------
    // bus and compare tasks
    // ------------------------------------------------------------
    task automatic wb_xfer(input logic w, input logic [4:0] idx, input logic [15:0] d,
                           input logic [3:0] s, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clock);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {1'b0, idx, 2'b00}; sel <= s; wdat <= {16'h0000, d};
        do begin
            @(posedge clock);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) error_cnt++;
        q = rdat;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask : wb_xfer

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t reg got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_out(input logic [23:0] got, input logic [23:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t out got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_out

    task automatic wr(input logic [4:0] idx, input logic [15:0] d, input logic [3:0] s = 4'hf);
        logic [31:0] q;
        wb_xfer(1'b1, idx, d, s, q);
    endtask : wr

    task automatic rd_chk(input logic [4:0] idx, input logic [15:0] exp);
        logic [31:0] q;
        wb_xfer(1'b0, idx, 16'h0000, 4'hf, q);
        chk_reg(q, {16'h0000, exp});
    endtask : rd_chk

    // outputs lag the ack edge, the dc coefficient by one more cycle
    task automatic settle();
        repeat (2) @(posedge clock);
        #1;
    endtask : settle

    task automatic conclude();
        $display("checks=%0d mismatches=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : conclude

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        reset = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'h0; wdat = 32'h0;
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        for (int i = 0; i < 7; i++) rd_chk(5'(12 + i), rst_val[i]);
        settle();
        chk_out(ch0_gain, 24'h800000);
        chk_out(ch1_gain, 24'h800000);
        chk_out(ch1_ofs, 24'h000000);
        chk_out({20'h0, ch1_dc}, 24'h000000);
        $display("test reset_values done");

        for (int i = 0; i < 7; i++) wr(5'(12 + i), 16'hffff);
        for (int i = 0; i < 7; i++) rd_chk(5'(12 + i), wr_mask[i]);
        $display("test reserved_bits done");

        wr(5'h0c, 16'h1234);
        wr(5'h0d, 16'h56ab);
        wr(5'h0e, 16'hfe41);
        wr(5'h0f, 16'h8001);
        wr(5'h10, 16'hff7e);
        wr(5'h11, 16'h4000);
        wr(5'h12, 16'h01ff);
        rd_chk(5'h0d, 16'h5600);
        rd_chk(5'h10, 16'hff00);
        rd_chk(5'h12, 16'h0100);
        settle();
        chk_out(ch0_gain, 24'h123456);
        chk_out(ch1_ofs, 24'h8001ff);
        chk_out(ch1_gain, 24'h400001);
        chk_out({14'h0, ch1_delay}, 24'h0003f9);
        chk_out({22'h0, ch1_insel}, 24'h000001);
        $display("test calibration_words done");

        for (int i = 0; i < 4; i++) begin
            wr(5'h0e, {10'h200, 3'b111, 1'b0, 2'(i)});
            rd_chk(5'h0e, {10'h200, 3'b000, 1'b0, 2'(i)});
            settle();
            chk_out({22'h0, ch1_insel}, 24'(i));
            chk_out({14'h0, ch1_delay}, 24'h000200);
        end
        $display("test input_select done");

        wr(5'h1c, 16'h000f);
        settle();
        chk_out({20'h0, ch1_dc}, 24'h00000f);
        rd_chk(5'h1d, 16'h001f);
        wr(5'h0e, 16'h0004);
        settle();
        chk_out({20'h0, ch1_dc}, 24'h000000);
        rd_chk(5'h1d, 16'h0000);
        wr(5'h0e, 16'h0000);
        settle();
        chk_out({20'h0, ch1_dc}, 24'h00000f);
        wr(5'h1c, 16'h0000);
        settle();
        chk_out({20'h0, ch1_dc}, 24'h000000);
        $display("test dc_filter done");

        wr(5'h0c, 16'h00aa, 4'h1);
        rd_chk(5'h0c, 16'h12aa);
        wr(5'h0c, 16'hbb00, 4'h2);
        rd_chk(5'h0c, 16'hbbaa);
        wr(5'h02, 16'hffff);
        rd_chk(5'h02, 16'h0000);
        rd_chk(5'h0c, 16'hbbaa);
        $display("test byte_lanes_unmapped done");

        @(posedge clock);
        reset <= 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        rd_chk(5'h0c, 16'h8000);
        rd_chk(5'h11, 16'h8000);
        rd_chk(5'h0e, 16'h0000);
        settle();
        chk_out(ch1_ofs, 24'h000000);
        chk_out(ch0_gain, 24'h800000);
        $display("test mid_run_reset done");
        conclude();
    end

endmodule : ccr_regs_tb
